/* bmx_mux_cfg.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - read/write config register at index 0x17
// - bit 21 isolates positive input, resets 1
// - bit 20 isolates negative input, resets 1
// - bits 19:18 positive calibration source, reset 00
// - bits 17:16 negative calibration source, reset 00
// - calibration voltage codes need cal enable set
// - bits 13:12 current generator mode, reset 00
// - bit 11 enables resistance self-test, reset 0
// - self-test only while cal enable clear
// - self-test opens drive, joins drive to inputs
// - self-test applies high-value lead bias resistors
// - bits 10:8 nominal resistance, reset 000
// - nominal codes 011+ engage extra switches
// - bits 6:4 modulated resistance, reset 100
// - bits 1:0 toggle divide 2^13..2^19
// - toggle square wave has half duty
// - toggle follows selected master clock rate
module bmx_mux_cfg (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  // neighbouring configuration
  input wire logic cal_voltage_enable,
  input wire logic mstr_tick,
  // analog front end controls
  output bmx_pkg::bmx_ctrl_t ctrl
);
  logic [23:0] cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic hit;
  logic [23:0] bemask;
  logic bist_run;
  logic toggle;
  logic [1:0] pos_sel, neg_sel;
  logic [2:0] rnom, rmod;

  assign hit = avs_address == bmx_pkg::BMX_REG_ADDR;
  assign bemask = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
    {8{avs_byteenable[0]}}};

  // one wait cycle per access keeps read data registered
  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if ((avs_read || avs_write) && !ack_r) begin
      ack_nxt = 1'b1;
      err_nxt = !hit;
      if (avs_read) begin
        rdata_nxt = hit ? {8'h00, cfg_r} : 32'h0000_0000;
      end
    end
    // the write lands on the completing edge, as the master sees it
    if (avs_write && ack_r && hit) begin
      cfg_nxt = (cfg_r & ~(bemask & bmx_pkg::BMX_WMASK)) |
        (avs_writedata[23:0] & bemask & bmx_pkg::BMX_WMASK);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= bmx_pkg::BMX_RST;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;
  assign avs_response_err = err_r;

  assign pos_sel = cfg_r[bmx_pkg::POS_CAL_L +: 2];
  assign neg_sel = cfg_r[bmx_pkg::NEG_CAL_L +: 2];
  assign rnom = cfg_r[bmx_pkg::RNOM_L +: 3];
  assign rmod = cfg_r[bmx_pkg::RMOD_L +: 3];
  // self-test is blocked while the cal voltage is on
  assign bist_run = cfg_r[bmx_pkg::BIST_EN_B] && !cal_voltage_enable;

  bmx_toggle_gen #(
    .CNT_W(bmx_pkg::DIV_CNT_W)
  ) u_tog (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(bist_run),
    .mstr_tick(mstr_tick),
    .freq_sel(cfg_r[bmx_pkg::FREQ_L +: 2]),
    .toggle(toggle)
  );

  always_comb begin
    ctrl = '0;
    ctrl.pos_isolated = cfg_r[bmx_pkg::POS_ISO_B];
    ctrl.neg_isolated = cfg_r[bmx_pkg::NEG_ISO_B];
    // voltage codes fall back to none without cal enable
    ctrl.pos_cal_route = (pos_sel[1] && !cal_voltage_enable) ?
      bmx_pkg::CAL_NONE : pos_sel;
    ctrl.neg_cal_route = (neg_sel[1] && !cal_voltage_enable) ?
      bmx_pkg::CAL_NONE : neg_sel;
    ctrl.current_generator_mode = cfg_r[bmx_pkg::CG_MODE_L +: 2];
    ctrl.selftest_active = bist_run;
    ctrl.drive_isolate_open = bist_run;
    ctrl.drive_to_input_closed = bist_run;
    ctrl.lead_bias_high_r = bist_run;
    if (bist_run) begin
      ctrl.nominal_switches = 8'h01 << rnom;
      // extra nominal switches only take modulation codes 000 and 001
      if (!rmod[2] && rmod != bmx_pkg::RMOD_RSVD &&
          !(rnom >= bmx_pkg::RNOM_EXTRA_MIN && rmod[1])) begin
        ctrl.modulation_switches = {3{toggle}} &
          (3'h1 << rmod[1:0]);
      end
    end
    ctrl.selftest_toggle = toggle;
  end

  property p_rst_val;
    @(posedge sys_clk)
    $rose(rst_n) |-> cfg_r == bmx_pkg::BMX_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value");
  property p_write;
    @(posedge sys_clk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && hit && avs_byteenable[2:0] == 3'h7
    |=> cfg_r == ($past(avs_writedata[23:0]) & bmx_pkg::BMX_WMASK);
  endproperty
  a_write: assert property (p_write) else $error("write lost");
  property p_unused;
    @(posedge sys_clk) disable iff (!rst_n)
    (cfg_r & ~bmx_pkg::BMX_WMASK) == 24'h00_0000;
  endproperty
  a_unused: assert property (p_unused) else $error("spare bit set");
  property p_pos_iso;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrl.pos_isolated == cfg_r[bmx_pkg::POS_ISO_B] &&
    ctrl.neg_isolated == cfg_r[bmx_pkg::NEG_ISO_B];
  endproperty
  a_pos_iso: assert property (p_pos_iso) else $error("isolation");
  property p_cal_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    !cal_voltage_enable |-> !ctrl.pos_cal_route[1] && !ctrl.neg_cal_route[1];
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("cal gate");
  property p_bist_block;
    @(posedge sys_clk) disable iff (!rst_n)
    cal_voltage_enable |-> !ctrl.selftest_active && !ctrl.selftest_toggle;
  endproperty
  a_bist_block: assert property (p_bist_block) else $error("bist");
  property p_bist_sw;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrl.selftest_active == (ctrl.drive_isolate_open &&
      ctrl.drive_to_input_closed && ctrl.lead_bias_high_r);
  endproperty
  a_bist_sw: assert property (p_bist_sw) else $error("bist switches");
  property p_nomod;
    @(posedge sys_clk) disable iff (!rst_n)
    rmod[2] || (rnom >= bmx_pkg::RNOM_EXTRA_MIN && rmod[1])
    |-> ctrl.modulation_switches == 3'h0;
  endproperty
  a_nomod: assert property (p_nomod) else $error("modulation");
  property p_tog_stable;
    @(posedge sys_clk) disable iff (!rst_n)
    bist_run && !mstr_tick && $stable(bist_run) && $stable(cfg_r)
    |=> !$stable(cfg_r) || !$stable(bist_run) || $stable(toggle);
  endproperty
  a_tog_stable: assert property (p_tog_stable) else $error("toggle");
  c_write: cover property (@(posedge sys_clk) avs_write && !avs_waitrequest);
  c_read: cover property (@(posedge sys_clk) avs_read && !avs_waitrequest);
  c_bist: cover property (@(posedge sys_clk) $rose(ctrl.selftest_active));
endmodule // bmx_mux_cfg
`default_nettype wire

/* bmx_pkg.sv */
package bmx_pkg;
  localparam logic [7:0] BMX_REG_IDX = 8'h17;
  localparam logic [9:0] BMX_REG_ADDR = 10'h05C;
  localparam int BMX_REG_W = 24;
  localparam logic [23:0] BMX_RST = 24'h30_0040;
  localparam logic [23:0] BMX_WMASK = 24'h3F_3F73;
  localparam int POS_ISO_B = 21;
  localparam int NEG_ISO_B = 20;
  localparam int POS_CAL_L = 18;
  localparam int NEG_CAL_L = 16;
  localparam int CG_MODE_L = 12;
  localparam int BIST_EN_B = 11;
  localparam int RNOM_L = 8;
  localparam int RMOD_L = 4;
  localparam int FREQ_L = 0;
  localparam int DIV_BASE_EXP = 13;
  localparam int DIV_STEP_EXP = 2;
  localparam int DIV_CNT_W = 19;
  localparam logic [1:0] CAL_NONE = 2'h0;
  localparam logic [1:0] CAL_MID = 2'h1;
  localparam logic [1:0] CAL_VPOS = 2'h2;
  localparam logic [1:0] CAL_VNEG = 2'h3;
  localparam logic [2:0] RNOM_EXTRA_MIN = 3'h3;
  localparam logic [2:0] RMOD_RSVD = 3'h3;

  typedef struct packed {
    logic pos_isolated;
    logic neg_isolated;
    logic [1:0] pos_cal_route;
    logic [1:0] neg_cal_route;
    logic [1:0] current_generator_mode;
    logic selftest_active;
    logic drive_isolate_open;
    logic drive_to_input_closed;
    logic lead_bias_high_r;
    logic [7:0] nominal_switches;
    logic [2:0] modulation_switches;
    logic selftest_toggle;
  } bmx_ctrl_t;
endpackage

/* bmx_toggle_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module bmx_toggle_gen #(
  parameter int CNT_W = bmx_pkg::DIV_CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic mstr_tick,
  input wire logic [1:0] freq_sel,
  // output
  output logic toggle
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [4:0] half_bit;

  // half period is the bit below the divide exponent
  always_comb begin
    half_bit = 5'(bmx_pkg::DIV_BASE_EXP - 1 +
      bmx_pkg::DIV_STEP_EXP * int'(freq_sel));
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = '0;
    end else if (mstr_tick) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // one counter bit is a square wave of exactly half duty
  assign toggle = run & cnt_r[half_bit];
endmodule // bmx_toggle_gen
`default_nettype wire

/* test_bioimpedance_input_mux_config.sv */
`timescale 1ns/1ns
`default_nettype none
module test_bioimpedance_input_mux_config;
  localparam logic [9:0] A = 10'h05C;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic avs_response_err;
  logic cal_voltage_enable = 1'b0;
  logic mstr_tick = 1'b1;
  logic slow = 1'b0;
  logic [3:0] be = 4'hf;
  bmx_pkg::bmx_ctrl_t ctrl;
  logic [19:0] got_c;
  logic [31:0] seed = 32'h0000_2e1e;
  logic [31:0] q;
  logic [31:0] w;
  logic e;
  int bad_count = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  // slow mode halves the master rate to show the divider follows it
  always @(posedge sys_clk) mstr_tick <= slow ? ~mstr_tick : 1'b1;
  assign got_c = {ctrl.pos_isolated, ctrl.neg_isolated, ctrl.pos_cal_route,
    ctrl.neg_cal_route, ctrl.current_generator_mode, ctrl.selftest_active,
    ctrl.drive_isolate_open, ctrl.drive_to_input_closed,
    ctrl.lead_bias_high_r, ctrl.nominal_switches};
  bmx_mux_cfg bmx_mux_cfg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(be),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err),
    .cal_voltage_enable(cal_voltage_enable),
    .mstr_tick(mstr_tick),
    .ctrl(ctrl)
  );
  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected control view; cal voltage codes fall back to none
  function automatic logic [31:0] ex(input logic [23:0] v, input logic c);
    logic t;
    t = v[11] & ~c;
    return {12'h000, v[21:20], (v[19] & ~c) ? 2'h0 : v[19:18],
      (v[17] & ~c) ? 2'h0 : v[17:16], v[13:12], {4{t}},
      t ? 8'h01 << v[10:8] : 8'h00};
  endfunction
  // expected modulation switches for a given toggle level
  function automatic logic [2:0] em(input logic [23:0] v, input logic c,
    input logic tg);
    if (!v[11] || c || v[6] || v[5:4] == 2'h3 || (v[10:8] >= 3'h3 && v[5]))
      return 3'h0;
    return {3{tg}} & (3'h1 << v[5:4]);
  endfunction
  task automatic bus(input logic wr, input logic [9:0] a,
    input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    e = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      chk(0, 1);
      complete_run();
    end
  endtask
  task automatic wt(input logic v, output int c);
    for (c = 0; c < 70000; c++) begin
      @(posedge sys_clk);
      if (ctrl.selftest_toggle === v) break;
    end
    if (c == 70000) begin
      chk(0, 1);
      complete_run();
    end
  endtask
  task automatic tgl(input logic [1:0] sel, input logic sl);
    int n;
    int h;
    int l;
    slow <= sl;
    // self-test off first so the divider restarts from zero
    bus(1'b1, A, 32'h0030_0000);
    bus(1'b1, A, 32'h0030_0800 | sel);
    n = (1 << (12 + 2 * sel)) * (sl ? 2 : 1);
    wt(1'b0, h);
    wt(1'b1, h);
    wt(1'b0, h);
    wt(1'b1, l);
    chk(h + 1, n);
    chk(l + 1, n);
    $display("toggle test sel %0d slow %0d done", sel, sl);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, A, 32'h0000_0000);
    chk(q, 32'h0030_0040);
    chk(got_c, ex(24'h30_0040, 1'b0));
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      w = (k == 0) ? 32'hffff_ffff : seed;
      cal_voltage_enable <= seed[31] & (k != 0);
      bus(1'b1, A, w);
      bus(1'b0, A, 32'h0000_0000);
      chk(q, w & 32'h003f_3f73);
      chk(e, 0);
      chk(got_c, ex(w[23:0], cal_voltage_enable));
      chk(ctrl.modulation_switches, em(w[23:0], cal_voltage_enable, ctrl.selftest_toggle));
    end
    $display("register test done");
    bus(1'b1, 10'h060, 32'h0000_0000);
    bus(1'b0, 10'h060, 32'h0000_0000);
    chk(q, 0);
    chk(e, 1);
    bus(1'b0, A, 32'h0000_0000);
    chk(q, w & 32'h003f_3f73);
    $display("unmapped test done");
    be <= 4'h1;
    bus(1'b1, A, 32'h00ff_ffff);
    be <= 4'hf;
    bus(1'b0, A, 32'h0000_0000);
    chk(q, (w & 32'h003f_3f00) | 32'h0000_0073);
    $display("byte lane test done");
    cal_voltage_enable <= 1'b0;
    tgl(2'h0, 1'b0);
    tgl(2'h1, 1'b0);
    tgl(2'h0, 1'b1);
    complete_run();
  end
endmodule // test_bioimpedance_input_mux_config
`default_nettype wire
